// File: src/drive_status_pkg.sv
// Shared constants and types for the drive status output logic.
// Assumes one 20 MHz core clock; currents, torques and frequencies are unsigned fixed units.
package drive_status_pkg;
    // Core clock rate and the control tick derived from it
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    // Control ticks per hour-counter step (one hour at a 1 ms tick)
    localparam int unsigned HOUR_S = 3600;
    localparam int unsigned HOUR_TICKS = HOUR_S * 1_000_000 / TICK_US;

    // Output function codes for terminal routing
    localparam logic [4:0] FUNC_TORQUE_LIMIT = 5'h0_A;
    localparam logic [4:0] FUNC_RUN_HOURS = 5'h0_B;
    localparam logic [4:0] FUNC_POWERED_HOURS = 5'h0_C;
    localparam logic [4:0] FUNC_THERMAL_WARN = 5'h0_D;

    // Torque limit mode: four quadrant values, otherwise the analog limit
    localparam logic [1:0] TQ_MODE_FOUR_VALUES = 2'h0;

    // Thermal characteristic codes
    localparam logic [1:0] CURVE_REDUCED = 2'h0;
    localparam logic [1:0] CURVE_CONSTANT = 2'h1;
    localparam logic [1:0] CURVE_FREE = 2'h2;

    // Frequencies in 0.1 Hz; derating factors in 1/256 of the level
    localparam logic [15:0] REDUCED_KNEE_FREQ = 16'h00C8;   // 20.0 Hz
    localparam logic [15:0] CONSTANT_KNEE_FREQ = 16'h0019;  // 2.5 Hz
    localparam logic [15:0] FREE_FREQ_MAX = 16'h0FA0;       // 400.0 Hz
    localparam logic [8:0] FACTOR_UNITY = 9'h100;
    localparam logic [8:0] FACTOR_REDUCED = 9'h0CD;         // 0.8
    localparam logic [8:0] FACTOR_CONSTANT = 9'h0E6;        // 0.9
    // Level limits in tenths of rated current
    localparam logic [3:0] LEVEL_MIN_TENTHS = 4'h2;
    localparam logic [3:0] LEVEL_MAX_TENTHS = 4'hC;
    localparam logic [6:0] WARN_PCT_MAX = 7'h64;            // 100 %

    localparam int unsigned HEAT_DECAY_SHIFT = 8;

    typedef struct packed {
        logic [15:0] freq;  // 0.1 Hz
        logic [15:0] curr;  // Zero disables the point
    } free_point_t;

    typedef struct packed {
        logic torque_limit;
        logic run_hours_over;
        logic powered_hours_over;
        logic thermal_warning;
    } status_flags_t;
endpackage

// File: src/drive_status_output_logic.sv
// Status output logic of a motor drive: torque limit, hour counters, thermal model.
// Assumes all inputs are synchronous to core_clk and stable for at least one control tick.
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_logic
    import drive_status_pkg::*;
#(
    parameter int unsigned N_TERM = 5,
    parameter int unsigned TICK_DIV = TICK_CYCLES,
    parameter int unsigned TICKS_PER_HOUR = HOUR_TICKS,
    parameter int unsigned HOURS_W = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    // Torque limiting
    input wire logic torque_limit_enable_in,
    input wire logic [1:0] torque_limit_mode_sel,
    input wire logic [15:0] torque_limit_value_1,
    input wire logic [15:0] torque_limit_value_2,
    input wire logic [15:0] torque_limit_value_3,
    input wire logic [15:0] torque_limit_value_4,
    input wire logic [15:0] torque_limit_analog,
    input wire logic [1:0] torque_quadrant,
    input wire logic [15:0] torque_now,
    // Hour counters
    input wire logic run_mode_in,
    input wire logic [HOURS_W-1:0] hours_threshold,
    output logic [HOURS_W-1:0] run_hours,
    output logic [HOURS_W-1:0] powered_hours,
    // Thermal model
    input wire logic [15:0] rated_current,
    input wire logic [15:0] output_current,
    input wire logic [15:0] output_freq,
    input wire logic [1:0] profile_sel,
    input wire logic [15:0] thermal_level_profile1,
    input wire logic [15:0] thermal_level_profile2,
    input wire logic [15:0] thermal_level_profile3,
    input wire logic [1:0] thermal_curve_sel_profile1,
    input wire logic [1:0] thermal_curve_sel_profile2,
    input wire logic [1:0] thermal_curve_sel_profile3,
    input wire free_point_t free_points [3],
    input wire logic [6:0] thermal_warning_threshold,
    output logic thermal_trip,
    output logic thermal_level_error,
    // Flags and terminal routing
    output status_flags_t flags,
    input wire logic [4:0] terminal_func [N_TERM],
    output logic [N_TERM-1:0] terminal_out
);
    localparam int unsigned HEAT_W = 32 + HEAT_DECAY_SHIFT + 1;

    // Control tick and hour tick dividers
    logic [31:0] tick_cnt, next_tick_cnt;
    logic [31:0] hour_cnt, next_hour_cnt;
    logic tick, hour_step;

    // Hours are counted in whole ticks so the hour step always lands on a flag sample
    always_comb begin
        tick = (tick_cnt == 32'(TICK_DIV - 1));
        next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        hour_step = tick && (hour_cnt == 32'(TICKS_PER_HOUR - 1));
        next_hour_cnt = hour_cnt;
        if (tick) begin
            next_hour_cnt = hour_step ? 32'h0000_0000 : hour_cnt + 32'h0000_0001;
        end
    end

    // Reset restarts the tick phase, so the first tick comes TICK_DIV cycles later
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_cnt <= '0;
            hour_cnt <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
            hour_cnt <= next_hour_cnt;
        end
    end

    // Hour counters; saturation keeps a raised flag from dropping on wrap
    logic [HOURS_W-1:0] next_run_hours, next_powered_hours;
    localparam logic [HOURS_W-1:0] HOURS_MAX = '1;

    always_comb begin
        next_run_hours = run_hours;
        next_powered_hours = powered_hours;
        if (hour_step) begin
            if (powered_hours != HOURS_MAX) begin
                next_powered_hours = powered_hours + 1'b1;
            end
            if (run_mode_in && run_hours != HOURS_MAX) begin
                next_run_hours = run_hours + 1'b1;
            end
        end
    end

    // Counter registers only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            run_hours <= '0;
            powered_hours <= '0;
        end else begin
            run_hours <= next_run_hours;
            powered_hours <= next_powered_hours;
        end
    end

    // Torque limit selection
    logic [15:0] torque_limit;

    // Quadrant picks one of four limits; any other mode uses the analog limit
    always_comb begin
        torque_limit = torque_limit_analog;
        if (torque_limit_mode_sel == TQ_MODE_FOUR_VALUES) begin
            case (torque_quadrant)
                2'h0: torque_limit = torque_limit_value_1;
                2'h1: torque_limit = torque_limit_value_2;
                2'h2: torque_limit = torque_limit_value_3;
                default: torque_limit = torque_limit_value_4;
            endcase
        end
    end

    // Active profile level and curve
    logic [15:0] level_raw, level_min, level_max, level;
    logic [1:0] curve_sel;
    logic [19:0] rated_x;

    // Profile code 3 falls back to profile 1 rather than leaving the level open
    always_comb begin
        case (profile_sel)
            2'h1: begin
                level_raw = thermal_level_profile2;
                curve_sel = thermal_curve_sel_profile2;
            end
            2'h2: begin
                level_raw = thermal_level_profile3;
                curve_sel = thermal_curve_sel_profile3;
            end
            default: begin
                level_raw = thermal_level_profile1;
                curve_sel = thermal_curve_sel_profile1;
            end
        endcase
        // A level outside the window is clamped, never taken as is
        rated_x = rated_current * LEVEL_MIN_TENTHS;
        level_min = 16'(rated_x / 20'h0_000A);
        rated_x = rated_current * LEVEL_MAX_TENTHS;
        level_max = 16'(rated_x / 20'h0_000A);
        level = level_raw;
        if (level_raw < level_min) begin
            level = level_min;
        end else if (level_raw > level_max) begin
            level = level_max;
        end
    end

    // Frequency derating; free points are taken in index order, lowest valid index first
    logic [8:0] factor;
    logic [24:0] scaled;
    logic [15:0] trip_level;

    always_comb begin
        factor = FACTOR_UNITY;
        trip_level = level;
        scaled = '0;
        case (curve_sel)
            CURVE_REDUCED: begin
                if (output_freq <= REDUCED_KNEE_FREQ) begin
                    factor = FACTOR_REDUCED;
                end
            end
            CURVE_CONSTANT: begin
                if (output_freq <= CONSTANT_KNEE_FREQ) begin
                    factor = FACTOR_CONSTANT;
                end
            end
            default: ;
        endcase
        // Factor is in 1/256, so bits 23:8 hold the derated level
        scaled = level * factor;
        trip_level = scaled[23:8];
        if (curve_sel == CURVE_FREE) begin
            trip_level = level;
            // Lowest valid index wins; points out of order give a coarse curve, not an error
            for (int i = 2; i >= 0; i--) begin
                // Zero current or out-of-range frequency disables a point
                if (free_points[i].curr != 16'h0000 && free_points[i].freq <= FREE_FREQ_MAX
                    && output_freq <= free_points[i].freq) begin
                    trip_level = free_points[i].curr;
                end
            end
        end
    end

    // Heat integrator: squared current in, proportional decay out
    logic [HEAT_W-1:0] heat, next_heat;
    logic [HEAT_W-1:0] trip_heat;
    logic [HEAT_W+6:0] warn_lhs, warn_rhs;
    logic [6:0] warn_pct;
    logic next_trip;

    // Decay by a shift avoids a divider; the time constant is 256 ticks
    always_comb begin
        next_heat = heat;
        if (tick) begin
            next_heat = heat + HEAT_W'(output_current * output_current)
                        - (heat >> HEAT_DECAY_SHIFT);
        end
        trip_heat = HEAT_W'(trip_level * trip_level) << HEAT_DECAY_SHIFT;
        warn_pct = (thermal_warning_threshold > WARN_PCT_MAX) ? WARN_PCT_MAX
                   : thermal_warning_threshold;
        // Both sides carry a percent factor so the comparison needs no divide
        warn_lhs = (HEAT_W + 7)'(heat) * 7'(WARN_PCT_MAX);
        warn_rhs = (HEAT_W + 7)'(trip_heat) * warn_pct;
        next_trip = thermal_trip || (tick && heat >= trip_heat);
    end

    // Trip stays latched until reset so a cooling motor cannot restart unnoticed
    always_ff @(posedge core_clk) begin
        if (rst) begin
            heat <= '0;
            thermal_trip <= 1'b0;
        end else begin
            heat <= next_heat;
            thermal_trip <= next_trip;
        end
    end

    // Status flags, sampled together on each control tick
    status_flags_t next_flags;
    logic next_level_error;

    always_comb begin
        next_flags = flags;
        next_level_error = thermal_level_error;
        if (tick) begin
            // Limiting only counts while the external enable is held
            next_flags.torque_limit = torque_limit_enable_in
                                      && (torque_now >= torque_limit);
            next_flags.run_hours_over = (run_hours > hours_threshold);
            next_flags.powered_hours_over = (powered_hours > hours_threshold);
            // Warning at or below the trip point, so below 100 % it leads the trip
            next_flags.thermal_warning = (warn_lhs > warn_rhs);
            next_level_error = (level_raw != level);
        end
    end

    // Flag registers only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags <= '0;
            thermal_level_error <= 1'b0;
        end else begin
            flags <= next_flags;
            thermal_level_error <= next_level_error;
        end
    end

    // Terminal routing; unknown function codes drive the terminal low
    logic [N_TERM-1:0] next_terminal_out;

    for (genvar t = 0; t < N_TERM; t++) begin : g_term
        always_comb begin
            case (terminal_func[t])
                FUNC_TORQUE_LIMIT: next_terminal_out[t] = next_flags.torque_limit;
                FUNC_RUN_HOURS: next_terminal_out[t] = next_flags.run_hours_over;
                FUNC_POWERED_HOURS: next_terminal_out[t] = next_flags.powered_hours_over;
                FUNC_THERMAL_WARN: next_terminal_out[t] = next_flags.thermal_warning;
                default: next_terminal_out[t] = 1'b0;
            endcase
        end
    end

    // Terminals change on the same edge as the flags they carry
    always_ff @(posedge core_clk) begin
        if (rst) begin
            terminal_out <= '0;
        end else begin
            terminal_out <= next_terminal_out;
        end
    end
endmodule
`default_nettype wire

// File: verif/drive_status_output_logic_checker.sv
// Port-level checker for the drive status output logic.
// Assumes TICK_DIV of 4 or more, static terminal codes and a steady threshold.
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_logic_checker
    import drive_status_pkg::*;
#(
    parameter int unsigned N_TERM = 5,
    parameter int unsigned HOURS_W = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic torque_limit_enable_in,
    input wire logic [1:0] torque_limit_mode_sel,
    input wire logic [15:0] torque_limit_value_1,
    input wire logic [15:0] torque_limit_value_2,
    input wire logic [15:0] torque_limit_value_3,
    input wire logic [15:0] torque_limit_value_4,
    input wire logic [15:0] torque_limit_analog,
    input wire logic [1:0] torque_quadrant,
    input wire logic [15:0] torque_now,
    input wire logic [HOURS_W-1:0] hours_threshold,
    input wire logic [HOURS_W-1:0] run_hours,
    input wire logic [HOURS_W-1:0] powered_hours,
    input wire logic [6:0] thermal_warning_threshold,
    input wire logic thermal_trip,
    input wire status_flags_t flags,
    input wire logic [4:0] terminal_func [N_TERM],
    input wire logic [N_TERM-1:0] terminal_out
);
    logic [15:0] lim;
    logic [N_TERM-1:0] exp_out;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Limit chosen by mode and quadrant
    assign lim = (torque_limit_mode_sel != TQ_MODE_FOUR_VALUES) ? torque_limit_analog :
        (torque_quadrant == 2'h0) ? torque_limit_value_1 :
        (torque_quadrant == 2'h1) ? torque_limit_value_2 :
        (torque_quadrant == 2'h2) ? torque_limit_value_3 : torque_limit_value_4;
    // Expected routing; only valid while codes stay put
    always_comb begin
        for (int i = 0; i < N_TERM; i++) begin
            case (terminal_func[i])
                FUNC_TORQUE_LIMIT: exp_out[i] = flags.torque_limit;
                FUNC_RUN_HOURS: exp_out[i] = flags.run_hours_over;
                FUNC_POWERED_HOURS: exp_out[i] = flags.powered_hours_over;
                FUNC_THERMAL_WARN: exp_out[i] = flags.thermal_warning;
                default: exp_out[i] = 1'b0;
            endcase
        end
    end
    a_torque_follows: assert property (
        $changed(flags.torque_limit) |->
        flags.torque_limit == $past(torque_limit_enable_in && torque_now >= lim))
        else $error("torque flag change without matching cause");
    a_flags_tick: assert property (
        $changed(flags) |=> $stable(flags)[*3])
        else $error("flags changed between ticks");
    a_route_terms: assert property (
        terminal_out == exp_out)
        else $error("terminal output not the routed flag");
    a_run_over: assert property (
        $rose(flags.run_hours_over) |-> $past(run_hours > hours_threshold))
        else $error("run flag rose at or below threshold");
    a_powered_over: assert property (
        flags.powered_hours_over |-> powered_hours > hours_threshold)
        else $error("powered flag without exceeding threshold");
    a_run_sticky: assert property (
        flags.run_hours_over |=> flags.run_hours_over)
        else $error("run flag dropped");
    a_hours_step: assert property (
        $changed(run_hours) |->
        {1'b0, run_hours} == {1'b0, $past(run_hours)} + 1'b1)
        else $error("run hours jumped or wrapped");
    a_powered_rate: assert property (
        $changed(powered_hours) |=> $stable(powered_hours)[*8])
        else $error("powered hours stepped too fast");
    a_warn_first: assert property (
        $rose(thermal_trip) && thermal_warning_threshold < 7'h64 |-> flags.thermal_warning)
        else $error("trip without warning");
endmodule
bind drive_status_output_logic drive_status_output_logic_checker #(
    .N_TERM(N_TERM), .HOURS_W(HOURS_W)) i_checker (.core_clk, .rst,
    .torque_limit_enable_in, .torque_limit_mode_sel, .torque_limit_value_1,
    .torque_limit_value_2, .torque_limit_value_3, .torque_limit_value_4,
    .torque_limit_analog, .torque_quadrant, .torque_now, .hours_threshold, .run_hours,
    .powered_hours, .thermal_warning_threshold, .thermal_trip, .flags, .terminal_func,
    .terminal_out);
`default_nettype wire

// File: verif/terminal_load_model.sv
// Far-side model: relay coils on the terminals and the controller's limit enable.
// Assumes one core clock; the controller holds the enable as a level.
`timescale 1ns/1ps
`default_nettype none
module terminal_load_model #(
    parameter int unsigned N_TERM = 5
) (
    input wire logic core_clk,
    input wire logic hold_limit,
    input wire logic [N_TERM-1:0] coil,
    output logic torque_limit_enable,
    output logic [N_TERM-1:0] contact
);
    // Enable stays up as long as limiting is wanted
    assign torque_limit_enable = hold_limit;
    // Contacts lag the coils by a clock, like a fast relay
    always_ff @(posedge core_clk) begin
        contact <= coil;
    end
endmodule
`default_nettype wire

// File: verif/drive_status_output_logic_tb.sv
// Testbench for the drive status output logic, short tick and hour counts.
// Assumes the package constants; terminal codes are held for the whole run.
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_logic_tb
    import drive_status_pkg::*;
;
    localparam int unsigned NT = 5;
    localparam int unsigned HW = 3;
    logic core_clk, rst, hold_limit, run_mode_in, trip, lvl_err, torque_limit_enable_in;
    logic [1:0] mode, quad, prof, curve;
    logic [15:0] tv [4];
    logic [15:0] lvl [3];
    logic [15:0] analog, tnow, cur, freq, rated;
    logic [HW-1:0] thr, run_h, pow_h;
    logic [6:0] pct;
    free_point_t fp [3];
    status_flags_t flags;
    logic [4:0] tf [NT];
    logic [NT-1:0] tout, contact;
    int n_errors, n_compared, cycles;

    drive_status_output_logic #(.N_TERM(NT), .TICK_DIV(4), .TICKS_PER_HOUR(3), .HOURS_W(HW))
    i_drive_status_output_logic (.core_clk, .rst, .torque_limit_enable_in,
        .torque_limit_mode_sel(mode), .torque_limit_value_1(tv[0]),
        .torque_limit_value_2(tv[1]), .torque_limit_value_3(tv[2]),
        .torque_limit_value_4(tv[3]), .torque_limit_analog(analog), .torque_quadrant(quad),
        .torque_now(tnow), .run_mode_in, .hours_threshold(thr), .run_hours(run_h),
        .powered_hours(pow_h), .rated_current(rated), .output_current(cur),
        .output_freq(freq), .profile_sel(prof), .thermal_level_profile1(lvl[0]),
        .thermal_level_profile2(lvl[1]), .thermal_level_profile3(lvl[2]),
        .thermal_curve_sel_profile1(curve), .thermal_curve_sel_profile2(2'h0),
        .thermal_curve_sel_profile3(2'h0), .free_points(fp),
        .thermal_warning_threshold(pct), .thermal_trip(trip),
        .thermal_level_error(lvl_err), .flags, .terminal_func(tf), .terminal_out(tout));
    terminal_load_model #(.N_TERM(NT)) i_terminal_load_model (.core_clk, .hold_limit,
        .coil(tout), .torque_limit_enable(torque_limit_enable_in), .contact);

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Inputs always move 1 ns after an edge
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic hours_test();
        wt(80);
        chk("powered_over", flags.powered_hours_over, 1);
        chk("run_idle", flags.run_hours_over, 0);
        run_mode_in = 1'b1;
        wt(24);
        chk("run_early", flags.run_hours_over, 0);
        wt(100);
        chk("run_over", flags.run_hours_over, 1);
        chk("run_sat", run_h, 7);
        chk("powered_sat", pow_h, 7);
        chk("relay_run", contact[1], 1);
    endtask
    task automatic tq(input logic en, input logic [1:0] m, q, input logic [15:0] t,
            input logic e);
        hold_limit = en;
        mode = m;
        quad = q;
        tnow = t;
        wt(12);
        chk("torque_flag", flags.torque_limit, e);
        chk("torque_term", tout[0], e);
    endtask
    task automatic torque_test();
        tq(1'b0, 2'h0, 2'h2, 16'h015E, 1'b0);
        tq(1'b1, 2'h0, 2'h2, 16'h015E, 1'b1);
        tq(1'b1, 2'h0, 2'h2, 16'h00FA, 1'b0);
        tq(1'b1, 2'h0, 2'h1, 16'h00FA, 1'b1);
        tq(1'b1, 2'h1, 2'h1, 16'h00FA, 1'b0);
    endtask
    // Profiles 2 and 3 hold out-of-range levels
    task automatic level_test();
        for (int p = 0; p < 4; p++) begin
            prof = p[1:0];
            wt(12);
            chk("level_error", lvl_err, (p == 1 || p == 2));
        end
        // A larger rated current widens the window around profile 2's level
        rated = 16'h0514;
        prof = 2'h1;
        wt(12);
        chk("level_rated", lvl_err, 0);
        rated = 16'h03E8;
        prof = 2'h0;
    endtask
    task automatic tcase(input logic [1:0] c, input logic [15:0] f, i, pf, pc,
            input logic [6:0] w, input logic et, ew);
        curve = c;
        freq = f;
        cur = i;
        pct = w;
        fp[0] = '{pf, pc};
        rst = 1'b1;
        wt(6);
        rst = 1'b0;
        wt(160);
        chk("trip_early", trip, 0);
        wt(3840);
        chk("trip", trip, et);
        chk("warn", flags.thermal_warning, ew);
        chk("warn_term", tout[3], ew);
    endtask
    task automatic thermal_test();
        tcase(2'h0, 16'h0064, 16'h0384, 16'h0, 16'h0, 7'h5A, 1'b1, 1'b1);
        tcase(2'h0, 16'h012C, 16'h0384, 16'h0, 16'h0, 7'h5A, 1'b0, 1'b0);
        tcase(2'h1, 16'h0014, 16'h03B6, 16'h0, 16'h0, 7'h5A, 1'b1, 1'b1);
        tcase(2'h1, 16'h0032, 16'h03B6, 16'h0, 16'h0, 7'h64, 1'b0, 1'b0);
        tcase(2'h2, 16'h0032, 16'h0258, 16'h0064, 16'h01F4, 7'h64, 1'b1, 1'b1);
        tcase(2'h2, 16'h0032, 16'h0258, 16'h0064, 16'h0, 7'h64, 1'b0, 1'b0);
        tcase(2'h2, 16'h0032, 16'h0258, 16'h0FA1, 16'h01F4, 7'h64, 1'b0, 1'b0);
        tcase(2'h0, 16'h012C, 16'h0384, 16'h0, 16'h0, 7'h32, 1'b0, 1'b1);
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        n_errors = 0;
        n_compared = 0;
        cycles = 0;
        rst = 1'b1;
        hold_limit = 1'b0;
        run_mode_in = 1'b0;
        mode = 2'h0;
        quad = 2'h2;
        tv = '{16'h0064, 16'h00C8, 16'h012C, 16'h0190};
        analog = 16'h01F4;
        rated = 16'h03E8;
        tnow = 16'h0000;
        thr = 3'h2;
        cur = 16'h0000;
        freq = 16'h0000;
        prof = 2'h0;
        curve = 2'h3;
        lvl = '{16'h03E8, 16'h0514, 16'h0096};
        pct = 7'h64;
        fp = '{default: '0};
        tf = '{FUNC_TORQUE_LIMIT, FUNC_RUN_HOURS, FUNC_POWERED_HOURS, FUNC_THERMAL_WARN, 5'h00};
        wt(6);
        rst = 1'b0;
        chk("flags_reset", flags, 0);
        hours_test();
        torque_test();
        level_test();
        thermal_test();
        close_out();
    end
endmodule
`default_nettype wire
